// file: verilog/sss_map.vh
`ifndef SSS_MAP_VH
`define SSS_MAP_VH

// Width of the shift chain and storage latch
`define SSS_WIDTH 8
// Index of stage seven and stage eight in the chain
`define SSS_STAGE7 6
`define SSS_STAGE8 7
// Word buffer depth and pointer width
`define SSS_FIFO_DEPTH 16
`define SSS_FIFO_AW 4
// Value that every stage, latch and output except the buffer ready takes under reset
`define SSS_RST_BYTE 8'h00
`define SSS_RST_BIT 1'b0

`endif

// file: verilog/sss_top.v
// Function
// - Each shift clock rise loads serial input into stage one, shifting the 8 stages.
// - Transfer high: latch follows shift stages; transfer low: latch and parallel outputs hold.
// - Parallel outputs driven only with output enable high; shifting never depends on it.
// - Early cascade takes stage seven on each rise, never changes on falls.
// - Late cascade takes stage eight on each fall; parallel outputs never move on falls.
`timescale 1ns/100ps
`include "sss_map.vh"

// Word buffer between the latch and downstream logic. The output stage is a
// register of its own, so the buffer holds DEPTH words in the array plus one
// more waiting on the output. Ready is registered, which costs one cycle of
// reaction when a full buffer frees a slot but keeps the input path short.
module sss_fifo #(
   parameter WIDTH = `SSS_WIDTH,
   parameter DEPTH = `SSS_FIFO_DEPTH,
   parameter AW = `SSS_FIFO_AW
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   // Filling side
   input wire in_valid_i,
   input wire [WIDTH-1:0] in_data_i,
   output reg in_ready_o,
   // Draining side
   output reg out_valid_o,
   output reg [WIDTH-1:0] out_data_o,
   input wire out_ready_i
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   reg [AW:0] count_d;
   wire push;
   wire pop;

   // Push only while not full; pop refills the output stage whenever it frees up
   assign push = in_valid_i & in_ready_o;
   assign pop = (count_q != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);

   // Occupancy next value
   // Push and pop in one cycle leave the occupancy alone
   always @* begin
      count_d = count_q;
      if (push & ~pop) begin
         count_d = count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
         count_d = count_q - {{AW{1'b0}}, 1'b1};
      end
   end

   // Storage array has no reset; only the pointers and flags need a defined value
   always @(posedge ref_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // Pointers, flags and registered output stage
   // Output stage refills as soon as downstream takes its word, so back-to-back words flow
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
         out_data_o <= {WIDTH{1'b0}};
      end else begin
         count_q <= count_d;
         in_ready_o <= (count_d != DEPTH[AW:0]); // Registered full flag
         if (push) begin
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            out_data_o <= mem_q[rd_ptr_q];
            out_valid_o <= 1'b1;
         end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
         end
      end
   end
endmodule // sss_fifo

// Shift chain, storage latch and cascade outputs. The host pins arrive with no
// relation to the reference clock, so every pin is synchronised and the shift
// clock is turned into rise and fall strobes. All state then runs on the
// reference clock; a pin edge shows up three reference edges later.
// The device side has no reset pin; the reference reset only gives the chain
// and latch a known start, and the host must not rely on it.
module sss_top (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   // Serial side pins from the host
   input wire shift_clock_i,
   input wire serial_in_i,
   input wire latch_transfer_i,
   input wire output_enable_i,
   // Three-state parallel outputs
   output reg [`SSS_WIDTH-1:0] parallel_out_o,
   output reg [`SSS_WIDTH-1:0] parallel_out_oe_o,
   // Cascade outputs
   output reg early_cascade_out_o,
   output reg late_cascade_out_o,
   // Latched word stream to downstream logic
   output wire word_valid_o,
   output wire [`SSS_WIDTH-1:0] word_data_o,
   input wire word_ready_i,
   output wire word_buf_ready_o,
   output reg word_drop_o
);
   // Two-stage synchronisers plus a third stage for edge detection
   reg [2:0] clk_sync_q;
   reg [1:0] din_sync_q;
   reg [1:0] xfer_sync_q;
   reg [1:0] oe_sync_q;
   reg [`SSS_WIDTH-1:0] shift_q;
   reg [`SSS_WIDTH-1:0] shift_d;
   reg [`SSS_WIDTH-1:0] latch_q;
   reg [`SSS_WIDTH-1:0] latch_d;
   reg push_q;
   wire clk_rise;
   wire clk_fall;
   wire buf_ready;

   // Pins come from outside this clock; first flops feed only the second ones
   // Reset clears the synchronisers, so a pin held high at release looks like a rise
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         clk_sync_q <= 3'h0;
         din_sync_q <= 2'h0;
         xfer_sync_q <= 2'h0;
         oe_sync_q <= 2'h0;
      end else begin
         clk_sync_q <= {clk_sync_q[1:0], shift_clock_i};
         din_sync_q <= {din_sync_q[0], serial_in_i};
         xfer_sync_q <= {xfer_sync_q[0], latch_transfer_i};
         oe_sync_q <= {oe_sync_q[0], output_enable_i};
      end
   end

   // Edges are taken between second and third stage, never from the first
   assign clk_rise = clk_sync_q[1] & ~clk_sync_q[2];
   assign clk_fall = ~clk_sync_q[1] & clk_sync_q[2];

   // Data is synchronised alongside the clock, so it is sampled with the same delay;
   // the host must keep the shift clock below half the reference rate for clean edges
   always @* begin
      shift_d = shift_q;
      if (clk_rise) begin
         shift_d = {shift_q[`SSS_WIDTH-2:0], din_sync_q[1]};
      end
   end

   // Latch is transparent while transfer is high, so it sees a shift in the same cycle
   // Transfer low keeps the old word, so the parallel outputs hold
   always @* begin
      latch_d = latch_q;
      if (xfer_sync_q[1]) begin
         latch_d = shift_d;
      end
   end

   // Chain, latch, parallel outputs and cascade outputs
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         shift_q <= `SSS_RST_BYTE;
         latch_q <= `SSS_RST_BYTE;
         parallel_out_o <= `SSS_RST_BYTE;
         parallel_out_oe_o <= `SSS_RST_BYTE;
         early_cascade_out_o <= `SSS_RST_BIT;
         late_cascade_out_o <= `SSS_RST_BIT;
      end else begin
         shift_q <= shift_d;
         latch_q <= latch_d;
         // Falls never touch the latch, so the parallel word cannot move on them
         parallel_out_o <= latch_d;
         parallel_out_oe_o <= {`SSS_WIDTH{oe_sync_q[1]}};
         // Early cascade shows the bit that moves into stage eight
         if (clk_rise) begin
            early_cascade_out_o <= shift_q[`SSS_STAGE7];
         end
         // Late cascade copies stage eight half a shift clock later
         if (clk_fall) begin
            late_cascade_out_o <= shift_q[`SSS_STAGE8];
         end
      end
   end

   // Queue each changed latch word; a full buffer drops it and flags the loss
   // A word that changes back and forth is queued every time; there is no merging
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         push_q <= 1'b0;
         word_drop_o <= 1'b0;
      end else begin
         push_q <= (latch_d != latch_q);
         word_drop_o <= push_q & ~buf_ready;
      end
   end

   assign word_buf_ready_o = buf_ready;

   // Word buffer; its ready is a flop inside the buffer
   sss_fifo #(
      .WIDTH(`SSS_WIDTH),
      .DEPTH(`SSS_FIFO_DEPTH),
      .AW(`SSS_FIFO_AW)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push_q),
      .in_data_i(latch_q),
      .in_ready_o(buf_ready),
      .out_valid_o(word_valid_o),
      .out_data_o(word_data_o),
      .out_ready_i(word_ready_i)
   );
endmodule // sss_top

// file: verif/sss_top_properties.sv
`timescale 1ns/100ps
module sss_chk (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   // Pins and outputs
   input wire shift_clock_i,
   input wire latch_transfer_i,
   input wire output_enable_i,
   input wire [7:0] parallel_out_o,
   input wire [7:0] parallel_out_oe_o,
   input wire early_cascade_out_o,
   input wire late_cascade_out_o,
   input wire word_valid_o,
   input wire [7:0] word_data_o,
   input wire word_ready_i
);
   // Pins pass two sync stages and one output register, so the cause sits three samples back
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   oe_uniform_a: assert property (parallel_out_oe_o == {8{parallel_out_oe_o[0]}})
      else $error("enable bits differ");
   oe_follow_a: assert property ($rose(output_enable_i) |-> ##[1:4] parallel_out_oe_o[0])
      else $error("enable not driven");
   early_rise_a: assert property ($changed(early_cascade_out_o) |-> $past(shift_clock_i, 3))
      else $error("early cascade moved off a rise");
   late_fall_a: assert property ($changed(late_cascade_out_o) |-> !$past(shift_clock_i, 3))
      else $error("late cascade moved off a fall");
   late_copy_a: assert property ($changed(late_cascade_out_o) |-> late_cascade_out_o == early_cascade_out_o)
      else $error("late cascade not stage eight");
   latch_hold_a: assert property (!$past(latch_transfer_i, 3) |-> $stable(parallel_out_o))
      else $error("latch moved with transfer low");
   cascade_match_a: assert property ($rose(early_cascade_out_o) && $past(latch_transfer_i, 3) |-> parallel_out_o[7])
      else $error("early cascade differs from stage eight");
   word_hold_a: assert property (word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_data_o))
      else $error("word dropped while stalled");
endmodule // sss_chk

bind sss_top sss_chk u_chk (
   .ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i),
   .shift_clock_i(shift_clock_i),
   .latch_transfer_i(latch_transfer_i),
   .output_enable_i(output_enable_i),
   .parallel_out_o(parallel_out_o),
   .parallel_out_oe_o(parallel_out_oe_o),
   .early_cascade_out_o(early_cascade_out_o),
   .late_cascade_out_o(late_cascade_out_o),
   .word_valid_o(word_valid_o),
   .word_data_o(word_data_o),
   .word_ready_i(word_ready_i)
);

// file: verif/sss_host.sv
`timescale 1ns/100ps
module sss_host (
   // Clock
   input wire ref_clk_i,
   // Serial side pins
   output reg shift_clock_o = 1'b0,
   output reg serial_o = 1'b0,
   output reg latch_transfer_o = 1'b0
);
   // Four cycles high and five low per bit keeps data steady across the two-stage sampling
   task send_byte(input [7:0] b, input x);
      integer i;
      latch_transfer_o <= x;
      for (i = 7; i >= 0; i = i - 1) begin
         @(posedge ref_clk_i) serial_o <= b[i];
         repeat (4) @(posedge ref_clk_i);
         shift_clock_o <= 1'b1;
         repeat (4) @(posedge ref_clk_i);
         shift_clock_o <= 1'b0;
      end
      serial_o <= ~b[0]; // Released line shows no stale bit
   endtask
   // Latch only after eight known bits are
   task strobe;
      latch_transfer_o <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      latch_transfer_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask
endmodule // sss_host

// file: verif/serial_shift_store_register_tb.sv
`timescale 1ns/100ps
module serial_shift_store_register_tb;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, oe = 1'b0, rdy = 1'b0, stall = 1'b0;
   wire sclk, sdin, xfer, early, late, wval, bufr, drop;
   wire [7:0] par, par_oe, wdat, npar;
   integer errors = 0, n_compared = 0, seed = 72856, k, n_drop = 0;
   logic [7:0] b, held, prev = 8'h00, last_word = 8'h00;
   always #2.5 ref_clk_i = ~ref_clk_i;
   // Downstream stalls at random, or holds off completely for the overrun corner
   always @(posedge ref_clk_i) rdy <= stall ? 1'b0 : 1'($random(seed));
   // Last word taken downstream and number of words lost, both at the handshake edge
   always @(posedge ref_clk_i) begin
      if (wval && rdy) last_word <= wdat;
      if (drop) n_drop <= n_drop + 1;
   end
   sss_host u_host (.ref_clk_i(ref_clk_i), .shift_clock_o(sclk), .serial_o(sdin), .latch_transfer_o(xfer));
   sss_top u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .shift_clock_i(sclk), .serial_in_i(sdin),
      .latch_transfer_i(xfer), .output_enable_i(oe), .parallel_out_o(par), .parallel_out_oe_o(par_oe),
      .early_cascade_out_o(early), .late_cascade_out_o(late), .word_valid_o(wval), .word_data_o(wdat),
      .word_ready_i(rdy), .word_buf_ready_o(bufr), .word_drop_o(drop));
   // Second device of a two-stage chain, fed from the late cascade for timing margin
   sss_top u_next (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .shift_clock_i(sclk), .serial_in_i(late),
      .latch_transfer_i(xfer), .output_enable_i(oe), .parallel_out_o(npar), .parallel_out_oe_o(),
      .early_cascade_out_o(), .late_cascade_out_o(), .word_valid_o(), .word_data_o(),
      .word_ready_i(1'b1), .word_buf_ready_o(), .word_drop_o());
   function logic [7:0] exp_oe(input logic en);
      return {8{en}};
   endfunction
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Waits, within a bound, until downstream has taken every queued word; samples off the edge
   task drain;
      integer t;
      t = 0;
      @(negedge ref_clk_i);
      while (wval && t < 200) begin
         @(negedge ref_clk_i);
         t++;
      end
      check("drained", {7'h00, wval}, 8'h00);
   endtask
   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      oe <= 1'b1;
      // Random bytes plus corners; last byte keeps transfer high so the latch tracks each shift
      for (k = 0; k < 7; k++) begin
         b = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'($random(seed));
         u_host.send_byte(b, k == 6);
         u_host.strobe();
         drain();
         check("parallel", par, b);
         check("enable", par_oe, exp_oe(1'b1));
         check("early", {7'h00, early}, {7'h00, b[7]});
         check("late", {7'h00, late}, {7'h00, b[7]});
         check("chained", npar, prev);
         check("word", last_word, b);
         prev = b;
      end
      check("lost", n_drop[7:0], 8'h00);
      $display("byte test done");
      // Transfer low and outputs floating while a new byte shifts
      held = b;
      b = ~held;
      oe <= 1'b0;
      u_host.send_byte(b, 1'b0);
      repeat (4) @(posedge ref_clk_i);
      drain();
      check("hold", par, held);
      check("float", par_oe, exp_oe(1'b0));
      check("early", {7'h00, early}, {7'h00, b[7]});
      check("late", {7'h00, late}, {7'h00, b[7]});
      $display("hold test done");
      // Downstream held off while alternating bits change the transparent latch on every shift
      stall = 1'b1;
      repeat (3) u_host.send_byte(8'h55, 1'b1);
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check("full", {7'h00, bufr}, 8'h00);
      check("lost", {7'h00, n_drop != 0}, 8'h01);
      check("parallel", par, 8'h55);
      stall = 1'b0;
      drain();
      check("ready", {7'h00, bufr}, 8'h01);
      $display("overrun test done");
      complete_run();
   end
endmodule // serial_shift_store_register_tb
